// file: logic/acg_pkg.sv
// constants and state types for the audio clock generator reference select
package acg_pkg;

  // ==========================================================================
  // bus and register map
  localparam int unsigned APB_AW = 18;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned REG_W  = 16;
  // printed offset is a register index; the byte address is four times it
  localparam logic [15:0]       REF_SEL_INDEX = 16'hf026;
  localparam logic [APB_AW-1:0] REF_SEL_ADDR  = {REF_SEL_INDEX, 2'h0};
  localparam logic [REG_W-1:0]  REF_SEL_RESET = 16'h000e;

  // ==========================================================================
  // field layout
  localparam int unsigned EXT_BIT = 4;
  localparam int unsigned PIN_LSB = 0;
  localparam int unsigned PIN_W   = 4;
  localparam int unsigned STRB_LANE0 = 0;
  localparam logic        EXT_RESET  = REF_SEL_RESET[EXT_BIT];
  localparam logic [PIN_W-1:0] PIN_RESET = REF_SEL_RESET[PIN_LSB +: PIN_W];

  // ==========================================================================
  // reference pin codes
  localparam int unsigned      NUM_MP      = 10;
  localparam logic [PIN_W-1:0] PIN_MP0     = 4'h0;
  localparam logic [PIN_W-1:0] PIN_MP1     = 4'h1;
  localparam logic [PIN_W-1:0] PIN_MP2     = 4'h2;
  localparam logic [PIN_W-1:0] PIN_MP_LAST = 4'h9;
  localparam logic [PIN_W-1:0] PIN_SPDIF   = 4'he;

  // ==========================================================================
  // rate arithmetic
  localparam int unsigned   MULT_W  = 16;
  localparam int unsigned   DIV_W   = 17;
  localparam int unsigned   ACC_W   = 20;
  localparam logic [DIV_W-1:0] EXT_DIV = 17'h00400;

  // ==========================================================================
  // state of the top module
  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [APB_DW-1:0]     prdata;
    logic                  ext_sel;
    logic [PIN_W-1:0]      pin_sel;
    logic                  last_ext;
    logic [PIN_W-1:0]      last_pin;
    logic                  ref_lvl;
    logic                  ref_ok;
    logic                  ref_edge;
  } acg_state_t;

endpackage : acg_pkg

// file: logic/acg_rate_acc.sv
// fractional rate accumulator: step per reference edge, tick per divisor
`timescale 1ns/1ps
`default_nettype none
module acg_rate_acc #(
  parameter int unsigned ACC_W  = 20,
  parameter int unsigned STEP_W = 16,
  parameter int unsigned DIV_W  = 17
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // reference step
  input  wire logic              step_valid,
  input  wire logic [STEP_W-1:0] step,
  input  wire logic [DIV_W-1:0]  divisor,
  // base rate
  output logic                   tick
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             tick;
  } acg_acc_t;

  acg_acc_t st_q;
  acg_acc_t st_d;

  // ==========================================================================
  // next state
  // ratios above one drain one tick per cycle; reference edges are far slower
  // than the core clock, so the backlog clears long before the next edge
  always_comb
  begin
    logic [ACC_W:0] sum;
    sum = {1'b0, st_q.acc};
    st_d = st_q;
    st_d.tick = 1'b0;
    if (step_valid)
    begin
      sum = sum + (ACC_W+1)'(step);
    end
    if (sum[ACC_W])
    begin
      sum = {1'b0, {ACC_W{1'b1}}};
    end
    // a zero divisor stalls the output instead of dividing by nothing
    if ((divisor != '0) && (sum >= (ACC_W+1)'(divisor)))
    begin
      sum = sum - (ACC_W+1)'(divisor);
      st_d.tick = 1'b1;
    end
    st_d.acc = sum[ACC_W-1:0];
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule : acg_rate_acc
`default_nettype wire

// file: logic/acg_ref_select.sv
// reference select and base rate generator for audio clock generator three
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module acg_ref_select (
  // clock and reset
  input  wire logic                       CORE_CLK,
  input  wire logic                       RESET,
  // apb slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [acg_pkg::APB_AW-1:0] PADDR,
  input  wire logic [acg_pkg::APB_DW-1:0] PWDATA,
  input  wire logic [3:0]                 PSTRB,
  output logic                            PREADY,
  output logic [acg_pkg::APB_DW-1:0]      PRDATA,
  output logic                            PSLVERR,
  // reference candidates
  input  wire logic                       PLL_REF_CLK,
  input  wire logic [acg_pkg::NUM_MP-1:0] MULTIPURPOSE_PIN_ANY,
  input  wire logic                       SPDIF_RATE_CLK,
  // generator ratio from the neighbouring registers
  input  wire logic [acg_pkg::MULT_W-1:0] NUMERATOR,
  input  wire logic [acg_pkg::MULT_W-1:0] DENOMINATOR,
  // status and base rate
  output logic                            EXT_REF_ACTIVE,
  output logic [acg_pkg::PIN_W-1:0]       REFERENCE_PIN_SELECT,
  output logic                            REF_LEVEL,
  output logic                            REF_VALID,
  output logic                            BASE_TICK
);

  acg_pkg::acg_state_t st_q;
  acg_pkg::acg_state_t st_d;

  logic                        addr_hit;
  logic                        wr_fire;
  logic                        sel_stable;
  logic                        ref_now;
  logic                        ref_ok_now;
  logic [acg_pkg::DIV_W-1:0]   divisor;
  logic [acg_pkg::REG_W-1:0]   reg_view;

  // ==========================================================================
  // register decode
  assign addr_hit = (PADDR == acg_pkg::REF_SEL_ADDR);
  assign wr_fire  = PSEL & PENABLE & st_q.pready & PWRITE & addr_hit
                  & PSTRB[acg_pkg::STRB_LANE0];
  assign sel_stable = (st_q.ext_sel == st_q.last_ext)
                    & (st_q.pin_sel == st_q.last_pin);

  // reserved bits read as zero and ignore writes
  always_comb
  begin
    reg_view = '0;
    reg_view[acg_pkg::EXT_BIT] = st_q.ext_sel;
    reg_view[acg_pkg::PIN_LSB +: acg_pkg::PIN_W] = st_q.pin_sel;
  end

  // ==========================================================================
  // reference mux
  always_comb
  begin
    ref_now    = 1'b0;
    ref_ok_now = 1'b1;
    if (!st_q.ext_sel)
    begin
      ref_now = PLL_REF_CLK;
    end
    else if (st_q.pin_sel <= acg_pkg::PIN_MP_LAST)
    begin
      ref_now = MULTIPURPOSE_PIN_ANY[st_q.pin_sel];
    end
    else if (st_q.pin_sel == acg_pkg::PIN_SPDIF)
    begin
      ref_now = SPDIF_RATE_CLK;
    end
    else
    begin
      ref_ok_now = 1'b0;
    end
  end

  // external reference divides by a fixed 1024, the pll path by M
  assign divisor = st_q.ext_sel ? acg_pkg::EXT_DIV
                                : {1'b0, DENOMINATOR};

  // ==========================================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // one wait state keeps every bus output straight from a flop
    st_d.pready  = PSEL & ~PENABLE;
    st_d.pslverr = PSEL & ~PENABLE & ~addr_hit;
    st_d.prdata  = '0;
    if (PSEL & ~PENABLE & ~PWRITE & addr_hit)
    begin
      st_d.prdata = acg_pkg::APB_DW'(reg_view);
    end
    if (wr_fire)
    begin
      st_d.ext_sel = PWDATA[acg_pkg::EXT_BIT];
      st_d.pin_sel = PWDATA[acg_pkg::PIN_LSB +: acg_pkg::PIN_W];
    end
    st_d.last_ext = st_q.ext_sel;
    st_d.last_pin = st_q.pin_sel;
    st_d.ref_lvl  = ref_now;
    st_d.ref_ok   = ref_ok_now;
    // a source switch swallows one edge so a level jump is not a false edge
    st_d.ref_edge = ref_now & ~st_q.ref_lvl & sel_stable;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      st_q         <= '0;
      st_q.ext_sel  <= acg_pkg::EXT_RESET;
      st_q.pin_sel  <= acg_pkg::PIN_RESET;
      st_q.last_ext <= acg_pkg::EXT_RESET;
      st_q.last_pin <= acg_pkg::PIN_RESET;
      st_q.ref_ok   <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // base rate accumulator
  acg_rate_acc #(
    .ACC_W  (acg_pkg::ACC_W),
    .STEP_W (acg_pkg::MULT_W),
    .DIV_W  (acg_pkg::DIV_W)
  ) u_rate (
    .clk        (CORE_CLK),
    .rst        (RESET),
    .step_valid (st_q.ref_edge),
    .step       (NUMERATOR),
    .divisor    (divisor),
    .tick       (BASE_TICK)
  );

  // ==========================================================================
  // outputs
  assign PREADY               = st_q.pready;
  assign PRDATA               = st_q.prdata;
  assign PSLVERR              = st_q.pslverr;
  assign EXT_REF_ACTIVE       = st_q.ext_sel;
  assign REFERENCE_PIN_SELECT = st_q.pin_sel;
  assign REF_LEVEL            = st_q.ref_lvl;
  assign REF_VALID            = st_q.ref_ok;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence

  sequence s_wr_done;
    PSEL && PENABLE && PREADY && PWRITE && addr_hit
      && PSTRB[acg_pkg::STRB_LANE0];
  endsequence

  sequence s_rise_ready;
    sel_stable && !st_q.ref_lvl;
  endsequence

  a_apb_one_wait: assert property (
    s_setup |=> PREADY ##1 !PREADY || (PSEL && !PENABLE))
    else $error("apb answer not exactly one wait state");

  a_pin_write: assert property (
    s_wr_done |=> (REFERENCE_PIN_SELECT
      == $past(PWDATA[acg_pkg::PIN_LSB +: acg_pkg::PIN_W]))
      && (EXT_REF_ACTIVE == $past(PWDATA[acg_pkg::EXT_BIT])))
    else $error("select field not updated by apb write");

  a_pll_path: assert property (
    (s_rise_ready and (!st_q.ext_sel && PLL_REF_CLK))
      |=> st_q.ref_edge && REF_VALID)
    else $error("pll reference edge not taken");

  a_ext_divide: assert property (
    st_q.ext_sel && st_q.ref_edge
      && ({1'b0, NUMERATOR} >= acg_pkg::EXT_DIV)
      |=> BASE_TICK)
    else $error("external reference not divided by 1024");

  a_mp_zero: assert property (
    (s_rise_ready and (st_q.ext_sel && st_q.pin_sel == acg_pkg::PIN_MP0
      && MULTIPURPOSE_PIN_ANY[acg_pkg::PIN_MP0])) |=> st_q.ref_edge)
    else $error("pin zero edge not routed");

  a_mp_one: assert property (
    (s_rise_ready and (st_q.ext_sel && st_q.pin_sel == acg_pkg::PIN_MP1
      && !MULTIPURPOSE_PIN_ANY[acg_pkg::PIN_MP0]
      && MULTIPURPOSE_PIN_ANY[acg_pkg::PIN_MP1]))
      |=> st_q.ref_edge && st_q.ref_lvl)
    else $error("pin one edge not routed");

  a_mp_upper: assert property (
    (s_rise_ready and (st_q.ext_sel && st_q.pin_sel >= acg_pkg::PIN_MP2
      && st_q.pin_sel <= acg_pkg::PIN_MP_LAST))
      |=> st_q.ref_edge == $past(MULTIPURPOSE_PIN_ANY[st_q.pin_sel]))
    else $error("upper multipurpose pin not routed");

  a_spdif_path: assert property (
    (s_rise_ready and (st_q.ext_sel && st_q.pin_sel == acg_pkg::PIN_SPDIF
      && SPDIF_RATE_CLK)) |=> st_q.ref_edge)
    else $error("s/pdif rate clock not routed");

  a_reset_code: assert property (
    $fell(RESET) |-> (REFERENCE_PIN_SELECT == acg_pkg::PIN_SPDIF)
      && !EXT_REF_ACTIVE)
    else $error("select register reset value wrong");

  a_reserved_code: assert property (
    st_q.ext_sel && st_q.pin_sel > acg_pkg::PIN_MP_LAST
      && st_q.pin_sel != acg_pkg::PIN_SPDIF |=> !REF_VALID && !REF_LEVEL)
    else $error("reserved code produced a reference");

  a_err_unmapped: assert property (
    (s_setup and !addr_hit) |=> PREADY && PSLVERR && (PRDATA == '0))
    else $error("unmapped address not refused");

  a_bus_quiet: assert property (
    !PREADY |-> !PSLVERR && (PRDATA == '0))
    else $error("bus outputs active outside the access cycle");

  a_read_field: assert property (
    (s_setup and (!PWRITE && addr_hit))
      |=> (PRDATA[acg_pkg::PIN_LSB +: acg_pkg::PIN_W]
        == $past(st_q.pin_sel))
      && (PRDATA[acg_pkg::EXT_BIT] == $past(st_q.ext_sel))
      && (PRDATA[acg_pkg::APB_DW-1:acg_pkg::EXT_BIT+1] == '0))
    else $error("select register read data wrong");

  a_strobe_off: assert property (
    PSEL && PENABLE && PREADY && PWRITE && !PSTRB[acg_pkg::STRB_LANE0]
      |=> $stable(REFERENCE_PIN_SELECT) && $stable(EXT_REF_ACTIVE))
    else $error("write without lane zero strobe changed the register");

  a_switch_drop: assert property (
    !sel_stable |=> !st_q.ref_edge)
    else $error("edge taken across a source switch");

  a_zero_denom: assert property (
    !st_q.ext_sel && (DENOMINATOR == '0) |=> !BASE_TICK)
    else $error("tick with a zero denominator");

  a_pll_level: assert property (
    !st_q.ext_sel |=> REF_LEVEL == $past(PLL_REF_CLK))
    else $error("pll reference level not followed");

  a_ext_valid: assert property (
    st_q.ext_sel && ((st_q.pin_sel <= acg_pkg::PIN_MP_LAST)
      || (st_q.pin_sel == acg_pkg::PIN_SPDIF)) |=> REF_VALID)
    else $error("assigned code reported as no reference");

endmodule : acg_ref_select
`default_nettype wire

// file: dv/acg_ref_src.sv
// square wave sources standing at the selector's reference inputs
`timescale 1ns/1ps
`default_nettype none
module acg_ref_src (
  // clock
  input  wire logic       clk,
  // toggling source: pin code, 4'he s/pdif, 4'hf pll
  input  wire logic [3:0] src,
  input  wire logic [3:0] half,
  // reference lines
  output logic [9:0]      mp,
  output logic            spdif,
  output logic            pll,
  output logic            wave
);
  // ==========================================================================
  // square wave
  logic [3:0] cnt = 4'h0;
  logic       lvl = 1'b0;
  // equal high and low phases of half cycles each
  always_ff @(posedge clk)
  begin
    cnt <= (cnt == half - 4'h1) ? 4'h0 : cnt + 4'h1;
    if (cnt == half - 4'h1)
      lvl <= ~lvl;
  end
  // idle lines sit low so only the chosen one can reach the generator
  assign wave  = lvl;
  assign mp    = (src < 4'ha) ? (10'h1 << src) & {10{lvl}} : 10'h0;
  assign spdif = (src == 4'he) & lvl;
  assign pll   = (src == 4'hf) & lvl;
endmodule : acg_ref_src
`default_nettype wire

// file: dv/acg_ref_select_tb.sv
// self-checking bench for the reference selector
`timescale 1ns/1ps
`default_nettype none
module acg_ref_select_tb;
  // ==========================================================================
  // signals
  logic                       clk, rst, psel, pen, pwr, prdy, perr;
  logic [acg_pkg::APB_AW-1:0] paddr;
  logic [31:0]                pwd, prd, rd;
  logic [3:0]                 pstrb, pin, src, half;
  logic [9:0]                 mp;
  logic                       spd, pll, wave, ext, lvl, vld, tick, er;
  logic                       wp, lp;
  logic [15:0]                num, den;
  int                         bad_count, check_count;
  int                         ticks, rises, lrises, r, l, t;

  acg_ref_select dut (.CORE_CLK(clk), .RESET(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
    .PSTRB(pstrb), .PREADY(prdy), .PRDATA(prd), .PSLVERR(perr),
    .PLL_REF_CLK(pll), .MULTIPURPOSE_PIN_ANY(mp),
    .SPDIF_RATE_CLK(spd), .NUMERATOR(num), .DENOMINATOR(den),
    .EXT_REF_ACTIVE(ext), .REFERENCE_PIN_SELECT(pin),
    .REF_LEVEL(lvl), .REF_VALID(vld), .BASE_TICK(tick));
  acg_ref_src src_model (.clk(clk), .src(src), .half(half), .mp(mp),
    .spdif(spd), .pll(pll), .wave(wave));

  // ==========================================================================
  // clock and counters
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    wp <= wave;
    lp <= lvl;
    rises <= rises + int'(wave === 1'b1 && wp === 1'b0);
    lrises <= lrises + int'(lvl === 1'b1 && lp === 1'b0);
    ticks <= ticks + int'(tick === 1'b1);
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // apb transfer; ready and data are taken at the rising edge that sees
  // ready high, and the request is released right after that edge
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    check("wait states", n, 32'h1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic sel(input logic [31:0] d);
    apb(1'b1, acg_pkg::REF_SEL_ADDR, d);
    check("slverr", {31'h0, er}, 32'h0);
  endtask : sel

  // let one source toggle, then count its edges, level edges and ticks
  task automatic run(input logic [3:0] s);
    @(posedge clk);
    src <= s;
    repeat (8) @(posedge clk);
    r = rises;
    l = lrises;
    t = ticks;
    repeat (200) @(posedge clk);
    r = rises - r;
    l = lrises - l;
    t = ticks - t;
  endtask : run

  function automatic logic [31:0] near(input int a, e);
    return {31'h0, a >= e - 2 && a <= e + 2};
  endfunction : near

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    apb(1'b0, acg_pkg::REF_SEL_ADDR, 32'h0);
    check("reset value", rd, 32'h0000000e);
    check("pin out", {28'h0, pin}, 32'he);
    sel(32'hffff_fff5);
    apb(1'b0, acg_pkg::REF_SEL_ADDR, 32'h0);
    check("readback", rd, 32'h15);
    check("ext out", {31'h0, ext}, 32'h1);
    pstrb <= 4'he;
    sel(32'h0);
    pstrb <= 4'hf;
    apb(1'b0, acg_pkg::REF_SEL_ADDR, 32'h0);
    check("strobe off", rd, 32'h15);
    apb(1'b1, acg_pkg::REF_SEL_ADDR + 18'h4, 32'h0);
    check("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b0, acg_pkg::REF_SEL_ADDR + 18'h4, 32'h0);
    check("unmapped data", rd, 32'h0);
  endtask : t_regs

  task automatic t_route;
    logic [3:0] c;
    for (int i = 0; i < 11; i++)
    begin
      c = (i == 10) ? 4'he : 4'(i);
      sel({27'h0, 1'b1, c});
      run(c);
      check("routed", near(l, r), 32'h1);
      check("valid", {31'h0, vld}, 32'h1);
      run(c == 4'h0 ? 4'h1 : 4'h0);
      check("other pin", l, 32'h0);
    end
  endtask : t_route

  task automatic t_reserved;
    logic [3:0] codes [5] = '{4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
    foreach (codes[i])
    begin
      sel({27'h0, 1'b1, codes[i]});
      run(4'h0);
      check("reserved", {31'h0, vld}, 32'h0);
      check("reserved level", l, 32'h0);
    end
  endtask : t_reserved

  task automatic t_rate;
    num <= 16'h0001;
    den <= 16'h0002;
    sel(32'h0);
    run(4'hf);
    check("pll ticks", near(t, r / 2), 32'h1);
    run(4'h0);
    check("pin ignored", t, 32'h0);
    num <= 16'h0800;
    den <= 16'h0007;
    sel(32'h1e);
    run(4'he);
    check("ext ticks", near(t, 2 * r), 32'h1);
  endtask : t_rate

  // ==========================================================================
  // run control
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end

  initial
  begin
    {rst, psel, pen, pwr, wp, lp} = 6'h20;
    {paddr, pwd, num, den} = '0;
    {pstrb, src, half} = 12'hf04;
    {bad_count, check_count, ticks, rises, lrises} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_route();
    t_reserved();
    t_rate();
    conclude();
  end
endmodule : acg_ref_select_tb
`default_nettype wire
